/* File: test/bdtc_master_model.sv */
// Secondary master model: repeats its delayed request some cycles
// after the bridge timer starts, but only when the bench arms it.
`timescale 1ns/1ps
`default_nettype none
module bdtc_master_model (
  input wire logic core_clk_i,
  input wire logic arm_i,
  input wire logic running_i,
  input wire logic [7:0] delay_i,
  output var logic retry_o = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  // Count timer cycles, repeat the request once at the set delay
  always @(posedge core_clk_i) begin
    cnt_q <= (arm_i && running_i) ? cnt_q + 8'h01 : 8'h00;
    retry_o <= #1 arm_i && running_i && (cnt_q == delay_i);
  end
endmodule
`default_nettype wire

/* File: test/bdtc_top_test.sv */
// Self-checking bench for the discard timer control block.
// Assumes the package, the design and the master model are compiled.
`timescale 1ns/1ps
`default_nettype none
module bdtc_top_test;
  import bdtc_pkg::*;
  localparam int LONG_N = 64;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, head = 1'b0;
  logic conv = 1'b1, aer = 1'b0, fsel = 1'b0, mask = 1'b0, arm = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [1:0] be = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic rvalid, running, discard, msg, fatal, retry, ssel;
  int err_total = 0, checks = 0, cycles = 0;
  bdtc_top #(.LONG_CYCLES(LONG_N)) u_dut (.core_clk_i(clk), .rst_i(rst),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .head_ready_i(head), .master_retry_i(retry), .conv_pci_mode_i(conv),
    .aer_present_i(aer), .aer_fatal_sel_i(fsel),
    .aer_discard_mask_i(mask), .timer_running_o(running),
    .discard_o(discard), .err_msg_o(msg), .err_fatal_o(fatal),
    .short_discard_select_o(ssel));
  bdtc_master_model u_master (.core_clk_i(clk), .arm_i(arm),
    .running_i(running), .delay_i(8'h14), .retry_o(retry));
  // Clock at 40 MHz
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // One config cycle after an idle edge, taken at the edge that follows
  task automatic cyc(input logic w, r, input logic [7:0] a,
                     input logic [1:0] b, input logic [15:0] d);
    @(posedge clk) #1;
    wr = w;
    rd = r;
    addr = a;
    be = b;
    wdata = d;
    @(posedge clk) #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    cyc(1'b0, 1'b1, a, 2'b10, 16'h0000);
    chk({15'h0, rvalid}, 16'h0001, "read answer");
    chk(rdata, e, "read data");
  endtask
  // Start the timer, count cycles to the drop, then look at the message
  task automatic expire(input int n, input logic m, f);
    int k;
    k = 1;
    head = 1'b1;
    @(posedge clk) #1;
    head = 1'b0;
    chk({15'h0, running}, 16'h0001, "timer running");
    while (discard !== 1'b1 && k < 2000) begin
      @(posedge clk) #1;
      k++;
    end
    chk(16'(k), 16'(n + 1), "discard delay");
    @(posedge clk) #1;
    chk({14'h0, msg, fatal & msg}, {14'h0, m, f & m}, "message");
  endtask
  task automatic t_regs();
    rd16(BRIDGE_CONTROL_OFS, 16'h0000);
    rd16(8'h3C, 16'h0000);
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b11, 16'hFFFF);
    chk({15'h0, ssel}, 16'h0001, "short select out");
    rd16(BRIDGE_CONTROL_OFS, 16'h0A00);
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b01, 16'h0000);
    rd16(BRIDGE_CONTROL_OFS, 16'h0A00);
    $display("register test done");
  endtask
  task automatic t_long();
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b10, 16'h0800);
    expire(LONG_N, 1'b1, 1'b0);
    rd16(BRIDGE_CONTROL_OFS, 16'h0C00);
    rd16(BRIDGE_CONTROL_OFS, 16'h0800);
    $display("long expiry test done");
  endtask
  task automatic t_modes();
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b10, 16'h0000);
    aer = 1'b1;
    fsel = 1'b1;
    expire(LONG_N, 1'b1, 1'b1);
    mask = 1'b1;
    expire(LONG_N, 1'b0, 1'b0);
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b10, 16'h0800);
    conv = 1'b0;
    expire(LONG_N, 1'b0, 1'b0);
    conv = 1'b1;
    $display("mode test done");
  endtask
  task automatic t_short();
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b10, 16'h0200);
    chk({15'h0, ssel}, 16'h0001, "short select out");
    expire(SHORT_DISCARD_CYCLES, 1'b0, 1'b0);
    $display("short interval test done");
  endtask
  task automatic t_retry();
    int k;
    k = 0;
    arm = 1'b1;
    head = 1'b1;
    @(posedge clk) #1;
    head = 1'b0;
    repeat (LONG_N + 20) begin
      @(posedge clk) #1;
      if (discard !== 1'b0) k++;
    end
    chk(16'(k), 16'h0000, "no drop after retry");
    chk({15'h0, running}, 16'h0000, "timer stopped");
    arm = 1'b0;
    $display("retry test done");
  endtask
  // Reset in mid-count clears the fields and the running timer
  task automatic t_reset();
    int k;
    k = 0;
    cyc(1'b1, 1'b0, BRIDGE_CONTROL_OFS, 2'b10, 16'h0A00);
    head = 1'b1;
    @(posedge clk) #1;
    head = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk({15'h0, running}, 16'h0000, "timer cleared");
    chk({15'h0, ssel}, 16'h0000, "short select cleared");
    repeat (SHORT_DISCARD_CYCLES + 20) begin
      @(posedge clk) #1;
      if (discard !== 1'b0) k++;
    end
    chk(16'(k), 16'h0000, "no drop after reset");
    rd16(BRIDGE_CONTROL_OFS, 16'h0000);
    $display("reset test done");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_regs();
    t_long();
    t_modes();
    t_short();
    t_retry();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/bdtc_pkg.sv */
// Package for the bridge discard timer control block: register map,
// field positions, reset values and timer lengths.
// Assumes a single 40 MHz clock, which is the secondary bus clock.
package bdtc_pkg;
  // Register offset and field positions
  localparam logic [7:0] BRIDGE_CONTROL_OFS = 8'h3E;
  localparam int DISCARD_ERR_EN_BIT = 11;
  localparam int DISCARD_FLAG_BIT = 10;
  localparam int SHORT_SEL_BIT = 9;
  localparam int PRI_SEL_BIT = 8;
  localparam logic [15:0] BRIDGE_CONTROL_RST = 16'h0000;
  // Discard intervals, in clock cycles of the secondary bus
  localparam int LONG_DISCARD_EXP = 15;
  localparam int SHORT_DISCARD_EXP = 10;
  localparam int LONG_DISCARD_CYCLES = 1 << LONG_DISCARD_EXP;
  localparam int SHORT_DISCARD_CYCLES = 1 << SHORT_DISCARD_EXP;
  localparam int DISCARD_CNT_W = 16;
  // Timer states
  typedef enum logic [0:0] {BDTC_IDLE, BDTC_RUN} bdtc_state_t;
endpackage

/* File: verilog/bdtc_timer.sv */
// Secondary discard timer: starts when a delayed completion is at the
// queue head, stops on a repeated request, pulses when it runs out.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bdtc_timer #(
  parameter int LONG_CYCLES = bdtc_pkg::LONG_DISCARD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic short_i,
  output logic running_o,
  output logic expire_o
);
  import bdtc_pkg::*;

  localparam logic [DISCARD_CNT_W-1:0] LONG_LAST =
    DISCARD_CNT_W'(LONG_CYCLES - 1);
  localparam logic [DISCARD_CNT_W-1:0] SHORT_LAST =
    DISCARD_CNT_W'(SHORT_DISCARD_CYCLES - 1);

  bdtc_state_t state_q, state_d;
  logic [DISCARD_CNT_W-1:0] cnt_q, cnt_d;
  logic expire_q, expire_d;
  logic [DISCARD_CNT_W-1:0] last_cnt;

  // Terminal count picked by the short select bit
  assign last_cnt = short_i ? SHORT_LAST : LONG_LAST;

  // Next state of the timer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    expire_d = 1'b0;
    case (state_q)
      BDTC_IDLE: begin
        if (start_i) begin
          state_d = BDTC_RUN;
          cnt_d = '0;
        end
      end
      BDTC_RUN: begin
        if (stop_i) begin
          state_d = BDTC_IDLE;
        end else if (cnt_q >= last_cnt) begin
          state_d = BDTC_IDLE;
          expire_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = BDTC_IDLE;
      end
    endcase
  end

  // Timer registers, cleared by reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= BDTC_IDLE;
      cnt_q <= '0;
      expire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      expire_q <= expire_d;
    end
  end

  assign running_o = (state_q == BDTC_RUN);
  assign expire_o = expire_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_start_needs_head: assert property (
    !running_o && !start_i |=> !running_o)
    else $error("Timer started without a completion at the head");
  a_expire_length: assert property (
    expire_o |-> $past(cnt_q) == $past(last_cnt))
    else $error("Timer expired at the wrong count");
  a_retry_stops: assert property (
    running_o && stop_i |=> !running_o && !expire_o)
    else $error("Repeated request did not stop the timer");
endmodule
`default_nettype wire

/* File: verilog/bdtc_top.sv */
// Bridge control register upper byte with the secondary discard timer
// and discard error signalling toward the primary side.
// Assumes config accesses and queue events come from same-clock logic.
// The lower byte of the register lives elsewhere and reads as zero here.
// A drop and a clearing read in one cycle leave the flag set.
//
// Function
// - Bits 15:12 always read as zero
// - Enabled expiry sends error message upstream in conventional PCI mode
// - Message is nonfatal unless advanced reporting selects fatal
// - Enable clear: message only via unmasked advanced reporting
// - Expiry sets flag; read clears it
// - Timer starts when completion reaches queue head
// - No retry before expiry: drop transaction
// - Interval 2^15 cycles, or 2^10 when short
// - Primary discard select reads zero, ignores writes
`timescale 1ns/1ps
`default_nettype none
module bdtc_top #(
  parameter int LONG_CYCLES = bdtc_pkg::LONG_DISCARD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic head_ready_i,
  input wire logic master_retry_i,
  input wire logic conv_pci_mode_i,
  input wire logic aer_present_i,
  input wire logic aer_fatal_sel_i,
  input wire logic aer_discard_mask_i,
  output logic timer_running_o,
  output logic discard_o,
  output logic err_msg_o,
  output logic err_fatal_o,
  output logic short_discard_select_o
);
  import bdtc_pkg::*;

  logic discard_error_msg_enable_q, discard_error_msg_enable_d;
  logic discard_expired_flag_q, discard_expired_flag_d;
  logic short_discard_select_q, short_discard_select_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic err_msg_q, err_msg_d;
  logic err_fatal_q, err_fatal_d;
  logic hit, wr_hi, rd_hi, expire, send_msg;
  logic [15:0] reg_view;

  // Address decode; only the upper byte holds live fields
  assign hit = (cfg_addr_i == BRIDGE_CONTROL_OFS);
  assign wr_hi = cfg_wr_i && hit && cfg_be_i[1];
  assign rd_hi = cfg_rd_i && hit && cfg_be_i[1];

  // Discard timer
  bdtc_timer #(
    .LONG_CYCLES(LONG_CYCLES)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(head_ready_i),
    .stop_i(master_retry_i),
    .short_i(short_discard_select_q),
    .running_o(timer_running_o),
    .expire_o(expire)
  );

  // Register view; reserved and primary select bits stay zero
  always_comb begin
    reg_view = 16'h0000;
    reg_view[DISCARD_ERR_EN_BIT] = discard_error_msg_enable_q;
    reg_view[DISCARD_FLAG_BIT] = discard_expired_flag_q;
    reg_view[SHORT_SEL_BIT] = short_discard_select_q;
  end

  // Error message decision on each dropped transaction
  assign send_msg = expire && conv_pci_mode_i &&
    (discard_error_msg_enable_q ||
     (aer_present_i && !aer_discard_mask_i));

  // Next values of fields, read data and error outputs
  always_comb begin
    discard_error_msg_enable_d = discard_error_msg_enable_q;
    short_discard_select_d = short_discard_select_q;
    if (wr_hi) begin
      discard_error_msg_enable_d = cfg_wdata_i[DISCARD_ERR_EN_BIT];
      short_discard_select_d = cfg_wdata_i[SHORT_SEL_BIT];
    end
    // Set wins over the clearing read
    discard_expired_flag_d = expire ||
      (discard_expired_flag_q && !rd_hi);
    rvalid_d = cfg_rd_i;
    rdata_d = (cfg_rd_i && hit) ? reg_view : 16'h0000;
    err_msg_d = send_msg;
    err_fatal_d = send_msg && aer_present_i && aer_fatal_sel_i;
  end

  // Registers; reset clears every field
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      discard_error_msg_enable_q <= BRIDGE_CONTROL_RST[DISCARD_ERR_EN_BIT];
      discard_expired_flag_q <= BRIDGE_CONTROL_RST[DISCARD_FLAG_BIT];
      short_discard_select_q <= BRIDGE_CONTROL_RST[SHORT_SEL_BIT];
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      err_msg_q <= 1'b0;
      err_fatal_q <= 1'b0;
    end else begin
      discard_error_msg_enable_q <= discard_error_msg_enable_d;
      discard_expired_flag_q <= discard_expired_flag_d;
      short_discard_select_q <= short_discard_select_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      err_msg_q <= err_msg_d;
      err_fatal_q <= err_fatal_d;
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign discard_o = expire;
  assign err_msg_o = err_msg_q;
  assign err_fatal_o = err_fatal_q;
  assign short_discard_select_o = short_discard_select_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Register view and message checks
  a_rsvd_reads_zero: assert property (
    cfg_rvalid_o |-> cfg_rdata_o[15:12] == 4'h0)
    else $error("Reserved bits read nonzero");
  a_enabled_msg_sent: assert property (
    discard_o && conv_pci_mode_i && discard_error_msg_enable_q
    |=> err_msg_o)
    else $error("Enabled discard did not send a message");
  a_default_nonfatal: assert property (
    discard_o && !(aer_present_i && aer_fatal_sel_i) |=> !err_fatal_o)
    else $error("Fatal severity without advanced reporting");
  a_disabled_no_msg: assert property (
    discard_o && !discard_error_msg_enable_q &&
    !(aer_present_i && !aer_discard_mask_i) |=> !err_msg_o)
    else $error("Message sent while disabled and masked");
  a_flag_on_discard: assert property (
    discard_o |=> discard_expired_flag_q ##1 1'b1)
    else $error("Discard did not set the flag");
  a_flag_read_clear: assert property (
    rd_hi && !discard_o |=> !discard_expired_flag_q)
    else $error("Read did not clear the flag");
  a_pri_sel_zero: assert property (
    wr_hi ##2 (cfg_rd_i && hit) |=> cfg_rdata_o[PRI_SEL_BIT] == 1'b0)
    else $error("Primary discard select not zero");
  a_reset_clears: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    rst_i |=> !timer_running_o &&
    !discard_expired_flag_q && !short_discard_select_q &&
    !discard_error_msg_enable_q)
    else $error("Reset left state behind");

  // Messages follow a drop; severity only qualifies a message
  a_msg_needs_drop: assert property (
    err_msg_o |-> $past(discard_o))
    else $error("Message sent without a dropped transaction");
  a_fatal_with_msg: assert property (
    err_fatal_o |-> err_msg_o)
    else $error("Fatal severity without a message");
  a_conv_mode_only: assert property (
    discard_o && !conv_pci_mode_i |=> !err_msg_o)
    else $error("Message sent outside conventional mode");
  a_unmasked_aer_msg: assert property (
    discard_o && conv_pci_mode_i && aer_present_i &&
    !aer_discard_mask_i |=> err_msg_o)
    else $error("Unmasked advanced reporting sent no message");
  a_fatal_when_sel: assert property (
    discard_o && conv_pci_mode_i && aer_present_i && aer_fatal_sel_i &&
    !aer_discard_mask_i |=> err_fatal_o)
    else $error("Selected fatal severity not used");

  // Flag moves only on a drop or a clearing read
  a_flag_holds: assert property (
    discard_expired_flag_q && !rd_hi |=> discard_expired_flag_q)
    else $error("Flag cleared without a read");
  a_flag_needs_drop: assert property (
    !discard_expired_flag_q && !discard_o |=> !discard_expired_flag_q)
    else $error("Flag set without a drop");
  a_read_shows_flag: assert property (
    cfg_rd_i && hit |=>
    cfg_rdata_o[DISCARD_FLAG_BIT] == $past(discard_expired_flag_q))
    else $error("Read data lost the flag");

  // Writes land in the upper byte only
  a_enable_write: assert property (
    wr_hi |=>
    discard_error_msg_enable_q == $past(cfg_wdata_i[DISCARD_ERR_EN_BIT]))
    else $error("Message enable write did not land");
  a_short_write: assert property (
    wr_hi |=> short_discard_select_o == $past(cfg_wdata_i[SHORT_SEL_BIT]))
    else $error("Short select write did not land");

  // Reads answer for one cycle; unmapped addresses read zero
  a_read_answer: assert property (
    cfg_rd_i |=> cfg_rvalid_o)
    else $error("Read got no answer");
  a_answer_one_cycle: assert property (
    !cfg_rd_i |=> !cfg_rvalid_o)
    else $error("Read answer stood too long");
  a_unmapped_zero: assert property (
    cfg_rd_i && !hit |=> cfg_rdata_o == 16'h0000)
    else $error("Unmapped address read nonzero");

  // A drop always ends the count
  a_drop_stops_timer: assert property (
    discard_o |-> !timer_running_o)
    else $error("Timer still running after a drop");

  c_discard_msg: cover property (discard_o ##1 err_msg_o);
  c_retry_in_time: cover property (timer_running_o && master_retry_i);
  c_flag_read: cover property (discard_expired_flag_q && rd_hi);
  c_short_drop: cover property (discard_o && short_discard_select_q);
  c_fatal_msg: cover property (err_msg_o && err_fatal_o);
endmodule
`default_nettype wire
